// >>> hw/sbcpm_pkg.sv
package sbcpm_pkg;
  localparam int CLK_MHZ = 100;
  localparam int STOP_DELAY_US = 20;
  localparam int STOP_DELAY_CYC = STOP_DELAY_US * CLK_MHZ;
  localparam int INT_PULSE_US = 10;
  localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
  localparam int CFG_WINDOW_MS = 350;
  localparam int CFG_WINDOW_CYC = CFG_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int RESET_PULSE_US = 10;
  localparam int RESET_PULSE_CYC = RESET_PULSE_US * CLK_MHZ;
  localparam int WD_PERIOD_DEF_CYC = 500000;
  localparam int TIMER_W = 26;

  localparam logic [1:0] SEL_STANDBY = 2'h0;
  localparam logic [1:0] SEL_NORMAL = 2'h1;
  localparam logic [1:0] SEL_STOP = 2'h2;
  localparam logic [1:0] SEL_SLEEP = 2'h3;

  localparam logic [3:0] WAKE_NONE = 4'h0;
  localparam logic [3:0] WAKE_INPUT = 4'h1;
  localparam logic [3:0] WAKE_CAN = 4'h2;
  localparam logic [3:0] WAKE_TIMER = 4'h4;
  localparam logic [3:0] WAKE_SPI = 4'h8;

  typedef enum logic [5:0] {
    SBCPM_NREQ = 6'h01,
    SBCPM_NORMAL = 6'h02,
    SBCPM_STANDBY = 6'h04,
    SBCPM_STOP_WAIT = 6'h08,
    SBCPM_STOP = 6'h10,
    SBCPM_SLEEP = 6'h20
  } sbcpm_mode_t;
endpackage

// >>> hw/sbcpm_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter: load starts it, done pulses one cycle, the cycle after it reaches one
module sbcpm_timer #(
  parameter int W = 26
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic load, // Start or restart the count
  input wire logic stop, // Abandon the count
  input wire logic [W-1:0] count, // Cycles to run
  output logic running, // Count in progress
  output logic done // One-cycle pulse at expiry
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic done;
  } sbcpm_tmr_t;

  sbcpm_tmr_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (load) begin
      st_nxt.cnt = count;
      st_nxt.run = 1'b1;
    end else if (stop) begin
      st_nxt.run = 1'b0;
    end else if (st_r.run) begin
      if (st_r.cnt <= W'(1)) begin
        st_nxt.run = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign running = st_r.run;
  assign done = st_r.done;
endmodule
`default_nettype wire

// >>> hw/sbcpm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sbcpm_ctrl #(
  parameter int CFG_WINDOW_CYC = sbcpm_pkg::CFG_WINDOW_CYC, // Configuration window
  parameter int WD_PERIOD_CYC = sbcpm_pkg::WD_PERIOD_DEF_CYC // Default watchdog period
) (
  input wire logic clk_sys, // 100 MHz internal clock
  input wire logic srst, // Synchronous reset, power-up
  input wire logic batt_low, // Battery under about 3V
  input wire logic mode_ctrl_rd, // Pulse: mode control register read
  input wire logic mode_wr, // Pulse: mode command, at end of message
  input wire logic [1:0] mode_sel, // Commanded mode
  input wire logic stop_watchdog_enable, // Watchdog runs in stop
  input wire logic wd_timing_wr, // Pulse: watchdog timing register write
  input wire logic [25:0] wd_timing_cyc, // Watchdog period written
  input wire logic hs_sw_on, // Register setting for the switch
  input wire logic cyclic_en, // Cyclic sense enabled
  input wire logic cyclic_tick, // Internal cyclic sense timer tick
  input wire logic wake_input_0, // Wake input 0 change event
  input wire logic wake_input_1, // Wake input 1 change event
  input wire logic forced_wake, // Forced wake timer expiry
  input wire logic can_wake, // CAN bus wake
  input wire logic chip_select_n, // SPI chip select
  input wire logic stop_overcurrent, // Above stop_current_wake_threshold
  input wire logic main_reg_good, // Main regulator fully active
  input wire logic tracking_uv, // Tracking regulator under 4.5V
  input wire logic hs_overtemp, // Switch overtemperature shutdown
  output logic main_reg_en, // Main regulator on
  output logic main_reg_lowpower, // Main regulator in stop state
  output logic ballast_drive, // Tracking regulator drive
  output logic can_en, // CAN interface enabled
  output logic wake_read_en, // Wake-input reading enabled
  output logic watchdog_run, // Software watchdog running
  output logic battery_high_side_switch, // Switch drive
  output logic wake_interrupt_pin_n, // Interrupt line, low active
  output logic reset_out_n, // Reset to microcontroller
  output logic batt_fail, // Supply-loss flag
  output logic [3:0] wake_source, // Recorded wake source bits
  output logic [1:0] io_status, // {switch overtemp, tracking undervoltage}
  output logic [5:0] mode_state // Current mode, one-hot
);
  typedef struct packed {
    sbcpm_pkg::sbcpm_mode_t mode;
    logic batt_fail;
    logic [3:0] wake_src;
    logic cs_n_d;
    logic int_pend;
    logic stop_wd;
    logic [25:0] wd_period;
    logic [1:0] io_st;
    logic [25:0] wait_cyc;
    logic boot;
  } sbcpm_state_t;

  sbcpm_state_t st_r, st_nxt;
  logic cfg_load, cfg_done, stop_load, stop_done;
  logic int_load, int_run, rst_load, rst_run, wd_load, wd_stop, wd_done;
  logic chip_wake, cs_rise;
  logic [3:0] wake_bits;

  sbcpm_timer #(.W(sbcpm_pkg::TIMER_W)) u_cfg (.clk_sys(clk_sys), .srst(srst),
    .load(cfg_load), .stop(st_r.mode != sbcpm_pkg::SBCPM_NREQ),
    .count(26'(CFG_WINDOW_CYC)), .running(), .done(cfg_done));
  // Expiry is acted on a cycle after the count ends, so the count is one short
  sbcpm_timer #(.W(sbcpm_pkg::TIMER_W)) u_stop (.clk_sys(clk_sys), .srst(srst),
    .load(stop_load), .stop(1'b0), .count(26'(sbcpm_pkg::STOP_DELAY_CYC - 1)),
    .running(), .done(stop_done));
  sbcpm_timer #(.W(sbcpm_pkg::TIMER_W)) u_int (.clk_sys(clk_sys), .srst(srst),
    .load(int_load), .stop(1'b0), .count(26'(sbcpm_pkg::INT_PULSE_CYC)),
    .running(int_run), .done());
  sbcpm_timer #(.W(sbcpm_pkg::TIMER_W)) u_rst (.clk_sys(clk_sys), .srst(srst),
    .load(rst_load), .stop(1'b0), .count(26'(sbcpm_pkg::RESET_PULSE_CYC)),
    .running(rst_run), .done());
  sbcpm_timer #(.W(sbcpm_pkg::TIMER_W)) u_wd (.clk_sys(clk_sys), .srst(srst),
    .load(wd_load), .stop(wd_stop), .count(st_r.wd_period),
    .running(), .done(wd_done));

  // Wake sources that count in low-power modes
  always_comb begin
    wake_bits = sbcpm_pkg::WAKE_NONE;
    if (wake_input_0 || wake_input_1) wake_bits = wake_bits | sbcpm_pkg::WAKE_INPUT;
    if (can_wake) wake_bits = wake_bits | sbcpm_pkg::WAKE_CAN;
    if (forced_wake) wake_bits = wake_bits | sbcpm_pkg::WAKE_TIMER;
  end
  assign cs_rise = chip_select_n && !st_r.cs_n_d;
  assign chip_wake = (wake_bits != sbcpm_pkg::WAKE_NONE);

  always_comb begin
    st_nxt = st_r;
    cfg_load = 1'b0;
    stop_load = 1'b0;
    int_load = 1'b0;
    rst_load = 1'b0;
    wd_load = 1'b0;
    wd_stop = 1'b0;
    st_nxt.cs_n_d = chip_select_n;
    st_nxt.boot = 1'b0;
    // Cycles spent waiting for stop, watched by the stop timing checks
    st_nxt.wait_cyc = (st_r.mode == sbcpm_pkg::SBCPM_STOP_WAIT)
      ? st_r.wait_cyc + 26'h0000001 : 26'h0000000;
    st_nxt.io_st = {hs_overtemp, tracking_uv};
    // Set wins over the read clear
    if (mode_ctrl_rd) st_nxt.batt_fail = 1'b0;
    if (batt_low) st_nxt.batt_fail = 1'b1;
    case (st_r.mode)
      sbcpm_pkg::SBCPM_NREQ: begin
        if (wd_timing_wr) begin
          st_nxt.mode = sbcpm_pkg::SBCPM_NORMAL;
          st_nxt.wd_period = wd_timing_cyc;
          wd_load = 1'b1;
        end else if (cfg_done) begin
          rst_load = 1'b1;
          cfg_load = 1'b1;
        end else if (st_r.boot) begin
          cfg_load = 1'b1;
        end
        // Interrupt waits for regulation after a chip-side wake
        if (st_r.int_pend && main_reg_good) begin
          st_nxt.int_pend = 1'b0;
          int_load = 1'b1;
        end
      end
      sbcpm_pkg::SBCPM_NORMAL, sbcpm_pkg::SBCPM_STANDBY: begin
        if (wd_timing_wr) begin
          st_nxt.wd_period = wd_timing_cyc;
          wd_load = 1'b1;
        end else if (wd_done) begin
          rst_load = 1'b1;
          wd_load = 1'b1;
        end
        if (mode_wr) begin
          case (mode_sel)
            sbcpm_pkg::SEL_NORMAL: st_nxt.mode = sbcpm_pkg::SBCPM_NORMAL;
            sbcpm_pkg::SEL_STANDBY: st_nxt.mode = sbcpm_pkg::SBCPM_STANDBY;
            sbcpm_pkg::SEL_STOP: begin
              st_nxt.mode = sbcpm_pkg::SBCPM_STOP_WAIT;
              st_nxt.stop_wd = stop_watchdog_enable;
              stop_load = 1'b1;
            end
            default: begin
              st_nxt.mode = sbcpm_pkg::SBCPM_SLEEP;
              wd_stop = 1'b1;
            end
          endcase
          if (mode_sel != sbcpm_pkg::SEL_STOP) st_nxt.wake_src = sbcpm_pkg::WAKE_NONE;
        end
      end
      sbcpm_pkg::SBCPM_STOP_WAIT: begin
        if (stop_done) begin
          st_nxt.mode = sbcpm_pkg::SBCPM_STOP;
          st_nxt.wake_src = sbcpm_pkg::WAKE_NONE;
          wd_load = st_r.stop_wd;
          wd_stop = !st_r.stop_wd;
        end
      end
      sbcpm_pkg::SBCPM_STOP: begin
        if (cs_rise || chip_wake || stop_overcurrent) begin
          st_nxt.mode = sbcpm_pkg::SBCPM_NREQ;
          cfg_load = 1'b1;
          wd_stop = 1'b1;
          st_nxt.wake_src = st_r.wake_src | wake_bits
            | (cs_rise ? sbcpm_pkg::WAKE_SPI : sbcpm_pkg::WAKE_NONE);
          if (cs_rise) begin
            int_load = 1'b1;
          end else begin
            st_nxt.int_pend = 1'b1;
          end
        end else if (st_r.stop_wd && wd_done) begin
          st_nxt.mode = sbcpm_pkg::SBCPM_NREQ;
          cfg_load = 1'b1;
          rst_load = 1'b1;
        end
      end
      sbcpm_pkg::SBCPM_SLEEP: begin
        if (cs_rise || chip_wake) begin
          st_nxt.mode = sbcpm_pkg::SBCPM_NREQ;
          cfg_load = 1'b1;
          st_nxt.wake_src = wake_bits
            | (cs_rise ? sbcpm_pkg::WAKE_SPI : sbcpm_pkg::WAKE_NONE);
        end
      end
      default: begin
        st_nxt.mode = sbcpm_pkg::SBCPM_NREQ;
        cfg_load = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
      st_r.mode <= sbcpm_pkg::SBCPM_NREQ;
      st_r.batt_fail <= 1'b1;
      st_r.cs_n_d <= 1'b1;
      st_r.boot <= 1'b1;
      st_r.wd_period <= 26'(WD_PERIOD_CYC);
    end else begin
      st_r <= st_nxt;
    end
  end

  // Mode decode of regulators and enables; all timing from clk_sys
  always_comb begin
    main_reg_en = st_r.mode != sbcpm_pkg::SBCPM_SLEEP;
    main_reg_lowpower = st_r.mode == sbcpm_pkg::SBCPM_STOP;
    ballast_drive = st_r.mode == sbcpm_pkg::SBCPM_NORMAL;
    can_en = st_r.mode == sbcpm_pkg::SBCPM_NORMAL;
    wake_read_en = (st_r.mode == sbcpm_pkg::SBCPM_NORMAL)
      || (st_r.mode == sbcpm_pkg::SBCPM_STANDBY);
    watchdog_run = wake_read_en || (st_r.mode == sbcpm_pkg::SBCPM_STOP && st_r.stop_wd);
    battery_high_side_switch = (wake_read_en && hs_sw_on)
      || (st_r.mode == sbcpm_pkg::SBCPM_SLEEP && cyclic_en && cyclic_tick);
  end

  assign wake_interrupt_pin_n = !int_run;
  assign reset_out_n = !rst_run;
  assign batt_fail = st_r.batt_fail;
  assign wake_source = st_r.wake_src;
  assign io_status = st_r.io_st;
  assign mode_state = st_r.mode;

  stop_delay_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.mode == sbcpm_pkg::SBCPM_NORMAL && mode_wr && mode_sel == sbcpm_pkg::SEL_STOP)
    |-> ##1 (mode_state == 6'h08) [*8])
    else $error("stop entered too early");
  batt_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    batt_low |=> batt_fail)
    else $error("battery loss not flagged");
  batt_clr_a: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_ctrl_rd && !batt_low) |=> !batt_fail)
    else $error("battery flag not cleared by read");
  cs_wake_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.mode == sbcpm_pkg::SBCPM_STOP && cs_rise) |=> ##1 !wake_interrupt_pin_n
      && mode_state == 6'h01)
    else $error("chip select wake missing");
  int_len_a: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(wake_interrupt_pin_n) |-> !wake_interrupt_pin_n [*8])
    else $error("interrupt pulse too short");
  nreq_cfg_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.mode == sbcpm_pkg::SBCPM_NREQ && wd_timing_wr) |=> mode_state == 6'h02)
    else $error("timing write did not enter normal");
  sleep_reg_a: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_state == 6'h20) |-> !main_reg_en && !ballast_drive)
    else $error("regulator on in sleep");
  stby_reg_a: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_state == 6'h04) |-> main_reg_en && !ballast_drive && !can_en && watchdog_run)
    else $error("standby enables wrong");
  io_stat_a: assert property (@(posedge clk_sys) disable iff (srst)
    ##1 io_status == $past({hs_overtemp, tracking_uv}))
    else $error("io status not tracking");
  stop_time_a: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_state == 6'h10 && $past(mode_state) == 6'h08)
    |-> st_r.wait_cyc == 26'(sbcpm_pkg::STOP_DELAY_CYC))
    else $error("stop not effective on the delay mark");
  stop_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_state == 6'h08) |-> st_r.wait_cyc < 26'(sbcpm_pkg::STOP_DELAY_CYC))
    else $error("stop wait too long");
  wd_expiry_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.mode == sbcpm_pkg::SBCPM_STOP && st_r.stop_wd && wd_done
      && !cs_rise && !chip_wake && !stop_overcurrent) |=> !reset_out_n && mode_state == 6'h01)
    else $error("stop watchdog expiry missed");
  cfg_rst_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.mode == sbcpm_pkg::SBCPM_NREQ && cfg_done && !wd_timing_wr) |=> !reset_out_n)
    else $error("configuration window reset missing");
  int_wait_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.mode == sbcpm_pkg::SBCPM_NREQ && st_r.int_pend && main_reg_good)
    |=> !wake_interrupt_pin_n)
    else $error("wake interrupt not raised");
  oc_no_src_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.mode == sbcpm_pkg::SBCPM_STOP && stop_overcurrent && !cs_rise && !chip_wake)
    |=> wake_source == sbcpm_pkg::WAKE_NONE && mode_state == 6'h01)
    else $error("overcurrent wake wrong");
  nreq_reg_a: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_state == 6'h01) |-> main_reg_en && !main_reg_lowpower && !ballast_drive)
    else $error("normal request enables wrong");
  norm_en_a: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_state == 6'h02) |-> main_reg_en && ballast_drive && can_en && wake_read_en
      && watchdog_run)
    else $error("normal enables wrong");
  stop_reg_a: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_state == 6'h10) |-> main_reg_en && main_reg_lowpower && !ballast_drive)
    else $error("stop regulators wrong");
  sleep_src_a: assert property (@(posedge clk_sys) disable iff (srst)
    (st_r.mode == sbcpm_pkg::SBCPM_SLEEP && forced_wake)
    |=> wake_source[2] && mode_state == 6'h01)
    else $error("sleep wake source lost");
endmodule
`default_nettype wire

// >>> dv/sbcpm_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Microcontroller side: SPI messages reduced to their end-of-message strobes
module sbcpm_mcu_model (
  input wire logic clk_sys, // System clock
  output logic chip_select_n, // SPI chip select
  output logic mode_wr, // Mode command strobe
  output logic [1:0] mode_sel, // Commanded mode
  output logic wd_timing_wr, // Timing write strobe
  output logic [25:0] wd_timing_cyc, // Timing value
  output logic mode_ctrl_rd // Mode register read strobe
);
  initial begin
    chip_select_n = 1'b1;
    mode_wr = 1'b0;
    mode_sel = 2'h0;
    wd_timing_wr = 1'b0;
    wd_timing_cyc = 26'h0;
    mode_ctrl_rd = 1'b0;
  end
  // Released data lines are inverted so a stale value never passes for a fresh one
  // A stop command is sent last; nothing follows until a wake
  task automatic spi_mode(input logic [1:0] sel);
    @(posedge clk_sys);
    #1;
    mode_sel = sel;
    mode_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    mode_wr = 1'b0;
    mode_sel = ~sel;
  endtask
  // Configures after a wake, then the bench commands a mode
  task automatic spi_timing(input logic [25:0] cyc);
    @(posedge clk_sys);
    #1;
    wd_timing_cyc = cyc;
    wd_timing_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    wd_timing_wr = 1'b0;
    wd_timing_cyc = ~cyc;
  endtask
  task automatic spi_read();
    @(posedge clk_sys);
    #1;
    mode_ctrl_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    mode_ctrl_rd = 1'b0;
  endtask
  // Held low for one cycle, then raised; the rising edge is an SPI wake from stop or sleep
  task automatic cs_wake();
    @(posedge clk_sys);
    #1;
    chip_select_n = 1'b0;
    @(posedge clk_sys);
    #1;
    chip_select_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_sbc_power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_sbc_power_mode_controller;
  localparam int CFG = 200;
  localparam logic [25:0] BIG = 26'h3FFFFFF;
  logic clk_sys, srst, batt_low, stop_watchdog_enable, hs_sw_on, cyclic_en, cyclic_tick;
  logic wake_input_0, wake_input_1, forced_wake, can_wake, stop_overcurrent;
  logic main_reg_good, tracking_uv, hs_overtemp, chip_select_n, mode_wr, wd_timing_wr;
  logic mode_ctrl_rd, main_reg_en, main_reg_lowpower, ballast_drive, can_en, wake_read_en;
  logic watchdog_run, battery_high_side_switch, wake_interrupt_pin_n, reset_out_n, batt_fail;
  logic rst_prev;
  logic [1:0] mode_sel, io_status;
  logic [25:0] wd_timing_cyc;
  logic [3:0] wake_source;
  logic [5:0] mode_state;
  wire logic [5:0] outs = {main_reg_en, main_reg_lowpower, ballast_drive, can_en,
    wake_read_en, watchdog_run};
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int int_run = 0;
  int int_len = 0;
  int int_fall = 0;
  int rst_fall = 0;

  sbcpm_mcu_model mcu (.clk_sys(clk_sys), .chip_select_n(chip_select_n), .mode_wr(mode_wr),
    .mode_sel(mode_sel), .wd_timing_wr(wd_timing_wr), .wd_timing_cyc(wd_timing_cyc),
    .mode_ctrl_rd(mode_ctrl_rd));
  sbcpm_ctrl #(.CFG_WINDOW_CYC(CFG), .WD_PERIOD_CYC(300)) DUT (.clk_sys(clk_sys), .srst(srst),
    .batt_low(batt_low), .mode_ctrl_rd(mode_ctrl_rd), .mode_wr(mode_wr), .mode_sel(mode_sel),
    .stop_watchdog_enable(stop_watchdog_enable), .wd_timing_wr(wd_timing_wr),
    .wd_timing_cyc(wd_timing_cyc), .hs_sw_on(hs_sw_on), .cyclic_en(cyclic_en),
    .cyclic_tick(cyclic_tick), .wake_input_0(wake_input_0), .wake_input_1(wake_input_1),
    .forced_wake(forced_wake), .can_wake(can_wake), .chip_select_n(chip_select_n),
    .stop_overcurrent(stop_overcurrent), .main_reg_good(main_reg_good),
    .tracking_uv(tracking_uv), .hs_overtemp(hs_overtemp), .main_reg_en(main_reg_en),
    .main_reg_lowpower(main_reg_lowpower), .ballast_drive(ballast_drive), .can_en(can_en),
    .wake_read_en(wake_read_en), .watchdog_run(watchdog_run),
    .battery_high_side_switch(battery_high_side_switch),
    .wake_interrupt_pin_n(wake_interrupt_pin_n), .reset_out_n(reset_out_n),
    .batt_fail(batt_fail), .wake_source(wake_source), .io_status(io_status),
    .mode_state(mode_state));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Pulse monitor: start cycle and length of each interrupt pulse, start of each reset
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rst_prev <= reset_out_n;
    if (reset_out_n === 1'b0 && rst_prev === 1'b1) rst_fall <= cyc;
    if (wake_interrupt_pin_n === 1'b0) begin
      int_run <= int_run + 1;
      if (int_run == 0) int_fall <= cyc;
    end else if (int_run != 0) begin
      int_len <= int_run;
      int_run <= 0;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_mode(input logic [5:0] m, input int lim);
    for (int k = 0; k < lim && mode_state !== m; k++)
      tick(1);
  endtask
  // The configuration window may keep reset low a while; proceed after a bound
  task automatic wait_rst_high();
    for (int k = 0; k < 3000 && reset_out_n !== 1'b1; k++)
      tick(1);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #700000;
    errors++;
    give_verdict();
  end
  initial begin
    logic [3:0] exp_src [6];
    int t0;
    int rf;
    exp_src = '{sbcpm_pkg::WAKE_INPUT, sbcpm_pkg::WAKE_INPUT, sbcpm_pkg::WAKE_CAN,
      sbcpm_pkg::WAKE_TIMER, sbcpm_pkg::WAKE_NONE, sbcpm_pkg::WAKE_SPI};
    {srst, main_reg_good} = 2'h3;
    {batt_low, stop_watchdog_enable, hs_sw_on, cyclic_en, cyclic_tick} = 5'h0;
    {wake_input_0, wake_input_1, can_wake, forced_wake, stop_overcurrent} = 5'h0;
    {tracking_uv, hs_overtemp} = 2'h0;
    tick(5);
    srst = 1'b0;
    tick(1);
    `CHK("mode", sbcpm_pkg::SBCPM_NREQ, mode_state)
    `CHK("nreq_reg", 2'h2, {main_reg_en, ballast_drive})
    `CHK("int_rst", 2'h3, {wake_interrupt_pin_n, reset_out_n})
    `CHK("batt_fail", 1'b1, batt_fail)
    mcu.spi_mode(sbcpm_pkg::SEL_NORMAL);
    `CHK("refused", sbcpm_pkg::SBCPM_NREQ, mode_state)
    mcu.spi_read();
    `CHK("batt_rd", 1'b0, batt_fail)
    batt_low = 1'b1;
    tick(1);
    batt_low = 1'b0;
    tick(1);
    `CHK("batt_set", 1'b1, batt_fail)
    mcu.spi_timing(BIG);
    `CHK("cfg_mode", sbcpm_pkg::SBCPM_NORMAL, mode_state)
    `CHK("norm_outs", 6'h2F, outs)
    hs_sw_on = 1'b1;
    tracking_uv = 1'b1;
    tick(2);
    `CHK("switch", 1'b1, battery_high_side_switch)
    `CHK("io", 2'h1, io_status)
    {tracking_uv, hs_overtemp} = 2'h1;
    tick(2);
    `CHK("io", 2'h2, io_status)
    hs_overtemp = 1'b0;
    mcu.spi_mode(sbcpm_pkg::SEL_STANDBY);
    `CHK("stby", sbcpm_pkg::SBCPM_STANDBY, mode_state)
    `CHK("stby_outs", 6'h23, outs)
    `CHK("switch", 1'b1, battery_high_side_switch)
    mcu.spi_mode(sbcpm_pkg::SEL_NORMAL);
    `CHK("norm", sbcpm_pkg::SBCPM_NORMAL, mode_state)
    for (int i = 0; i < 6; i++) begin
      mcu.spi_mode(sbcpm_pkg::SEL_STOP);
      `CHK("stop_wait", sbcpm_pkg::SBCPM_STOP_WAIT, mode_state)
      tick(sbcpm_pkg::STOP_DELAY_CYC - 1);
      `CHK("stop_wait", sbcpm_pkg::SBCPM_STOP_WAIT, mode_state)
      tick(1);
      `CHK("stop", sbcpm_pkg::SBCPM_STOP, mode_state)
      `CHK("stop_outs", 4'hC, outs[5:2])
      main_reg_good = 1'b0;
      rf = rst_fall;
      case (i)
        0: wake_input_0 = 1'b1;
        1: wake_input_1 = 1'b1;
        2: can_wake = 1'b1;
        3: forced_wake = 1'b1;
        4: stop_overcurrent = 1'b1;
        default: mcu.cs_wake();
      endcase
      wait_mode(sbcpm_pkg::SBCPM_NREQ, 5);
      t0 = cyc;
      `CHK("wake_mode", sbcpm_pkg::SBCPM_NREQ, mode_state)
      `CHK("full_reg", 2'h2, outs[5:4])
      {wake_input_0, wake_input_1, can_wake, forced_wake, stop_overcurrent} = 5'h0;
      tick(20);
      `CHK("wake_src", exp_src[i], wake_source)
      main_reg_good = 1'b1;
      if (i < 5) begin
        tick(80);
        mcu.spi_timing(BIG);
        `CHK("cfg_mode", sbcpm_pkg::SBCPM_NORMAL, mode_state)
        tick(1100);
        `CHK("int_delay", 1'b1, int_fall >= t0 + 19 && int_fall <= t0 + 25)
        `CHK("no_reset", rf, rst_fall)
      end else begin
        tick(1200);
        `CHK("int_delay", 1'b1, int_fall >= t0 - 3 && int_fall <= t0 + 3)
        `CHK("cfg_rst", 1'b1, rst_fall >= t0 + CFG - 5 && rst_fall <= t0 + CFG + 5)
      end
      `CHK("int_len", sbcpm_pkg::INT_PULSE_CYC, int_len)
    end
    wait_rst_high();
    mcu.spi_timing(26'hBB8);
    stop_watchdog_enable = 1'b1;
    mcu.spi_mode(sbcpm_pkg::SEL_STOP);
    wait_mode(sbcpm_pkg::SBCPM_STOP, sbcpm_pkg::STOP_DELAY_CYC + 5);
    `CHK("wd_stop", sbcpm_pkg::SBCPM_STOP, mode_state)
    `CHK("wd_rst_hi", 1'b1, reset_out_n)
    for (int k = 0; k < 6000 && reset_out_n !== 1'b0; k++)
      tick(1);
    `CHK("wd_rst", 1'b0, reset_out_n)
    wait_mode(sbcpm_pkg::SBCPM_NREQ, 5);
    `CHK("wd_mode", sbcpm_pkg::SBCPM_NREQ, mode_state)
    stop_watchdog_enable = 1'b0;
    wait_rst_high();
    mcu.spi_timing(BIG);
    mcu.spi_mode(sbcpm_pkg::SEL_SLEEP);
    `CHK("sleep", sbcpm_pkg::SBCPM_SLEEP, mode_state)
    `CHK("sleep_reg", 2'h0, {main_reg_en, ballast_drive})
    tick(3);
    `CHK("sleep_sw", 1'b0, battery_high_side_switch)
    {cyclic_en, cyclic_tick} = 2'h3;
    tick(1);
    `CHK("sleep_pulse", 1'b1, battery_high_side_switch)
    {cyclic_en, cyclic_tick} = 2'h0;
    forced_wake = 1'b1;
    wait_mode(sbcpm_pkg::SBCPM_NREQ, 5);
    forced_wake = 1'b0;
    `CHK("sleep_wake", sbcpm_pkg::SBCPM_NREQ, mode_state)
    tick(2);
    `CHK("sleep_src", sbcpm_pkg::WAKE_TIMER, wake_source)
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    t0 = cyc;
    tick(1);
    `CHK("boot_mode", sbcpm_pkg::SBCPM_NREQ, mode_state)
    tick(CFG + 10);
    `CHK("boot_rst", 1'b1, rst_fall >= t0 + CFG - 5 && rst_fall <= t0 + CFG + 5)
    give_verdict();
  end
endmodule
`default_nettype wire
